// ---- mcdp_map.vh ----
// register map, reset values, field positions and timing counts
`ifndef MCDP_MAP_VH
`define MCDP_MAP_VH

`define MCDP_ADDR_W        8
`define MCDP_OFS_DROP      8'h00
`define MCDP_OFS_CAP       8'h04
`define MCDP_OFS_SHIFT     8'h08
`define MCDP_OFS_FREF      8'h0c
`define MCDP_OFS_FGAIN     8'h10
`define MCDP_OFS_TCAL      8'h14
`define MCDP_OFS_TC_FIRST  8'h18
`define MCDP_OFS_TC_LAST   8'h2c
`define MCDP_OFS_CTRL      8'h30
`define MCDP_OFS_STAT      8'h34
`define MCDP_OFS_FREQ      8'h38

`define MCDP_RST_DROP      16'h0000
`define MCDP_RST_CAP       16'h0000
`define MCDP_RST_SHIFT     16'h1c20
`define MCDP_RST_FREF      16'hc350
`define MCDP_RST_FGAIN     16'h8000
`define MCDP_RST_TCAL      10'h200
`define MCDP_RST_TCOEF     16'h0000

`define MCDP_SHIFT_DROP_HI 15
`define MCDP_SHIFT_DROP_LO 8
`define MCDP_SHIFT_CAP_HI  7
`define MCDP_SHIFT_CAP_LO  0

`define MCDP_CTRL_FCAL     0
`define MCDP_CTRL_TCAP     1
`define MCDP_STAT_ACK      0
`define MCDP_STAT_NAK      1
`define MCDP_STAT_BUSY     2
`define MCDP_STAT_DC       3
`define MCDP_STAT_BAND     4

`define MCDP_GAIN_SHIFT    8'd15
`define MCDP_TEMP_SHIFT    8'd24
`define MCDP_BAND_LO       16'hafc8
`define MCDP_BAND_HI       16'hfde8
`define MCDP_DIV_STEPS     5'd31

`define MCDP_RESP_OKAY     2'b00
`define MCDP_RESP_SLVERR   2'b10

`endif

// ---- mcdp_comp.v ----
// one compensation term: saturating x plus or minus (coeff*operand)>>shift
`timescale 1ns/1ps
`default_nettype none
module mcdp_comp (
  input  wire [31:0] x,
  input  wire        x_signed,
  input  wire [15:0] coeff,
  input  wire [47:0] operand,
  input  wire [7:0]  shift,
  input  wire        subtract,
  output reg  [31:0] y
);
  localparam signed [65:0] S_MAX = 66'sh0_0000_0000_7fff_ffff;
  localparam signed [65:0] S_MIN = -66'sh0_0000_0000_8000_0000;
  localparam signed [65:0] U_MAX = 66'sh0_0000_0000_ffff_ffff;
  localparam signed [65:0] U_MIN = 66'sh0;

  // full-width product first, then truncating shift
  wire        [63:0] prod = coeff * operand;
  wire        [63:0] term = prod >> shift;
  wire signed [65:0] xs   = x_signed ? {{34{x[31]}}, x} : {34'h0, x};
  wire signed [65:0] ts   = {2'b00, term};
  wire signed [65:0] sum  = subtract ? xs - ts : xs + ts;

  // clamp instead of wrap
  always @* begin
    y = sum[31:0];
    if (x_signed) begin
      if (sum > S_MAX)
        y = S_MAX[31:0];
      else if (sum < S_MIN)
        y = S_MIN[31:0];
    end else begin
      if (sum > U_MAX)
        y = U_MAX[31:0];
      else if (sum < U_MIN)
        y = 32'h0000_0000;
    end
  end
endmodule // mcdp_comp
`default_nettype wire

// ---- mcdp_top.v ----
// measurement compensation datapath with frequency calibration and register file
`timescale 1ns/1ps
`default_nettype none
`include "mcdp_map.vh"
module mcdp_top (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        CE,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        DC_MODE,
  input  wire        MEAS_STROBE,
  input  wire [9:0]  TEMP_ADC,
  input  wire [15:0] FREQ_RAW,
  input  wire [31:0] IRMS_RAW,
  input  wire [31:0] VRMS_RAW,
  input  wire [31:0] PACT_RAW,
  input  wire [31:0] PREACT_RAW,
  output wire [15:0] LINE_FREQ,
  output wire [31:0] IRMS,
  output wire [31:0] VRMS,
  output wire [31:0] PACT,
  output wire [31:0] PREACT,
  output wire        RESULT_VALID,
  output wire        FREQ_IN_BAND,
  output wire        CAL_ACK,
  output wire        CAL_NAK
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DIV  = 2'd1;
  localparam [1:0] ST_DONE = 2'd2;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `MCDP_OFS_FREQ);
    end
  endfunction

  function [15:0] sat16;
    input [31:0] v;
    begin
      sat16 = (v > 32'h0000_ffff) ? 16'hffff : v[15:0];
    end
  endfunction

  function [31:0] mag32;
    input [31:0] v;
    input        s;
    begin
      mag32 = (s && v[31]) ? (~v + 32'h1) : v;
    end
  endfunction

  // registers
  reg  [15:0] drop_coef_ff, cap_coef_ff, shift_sel_ff;
  reg  [15:0] fref_ff, fgain_ff;
  reg  [9:0]  tcal_ff;
  reg  [15:0] tcoef_ff [0:5];
  reg         ack_ff, nak_ff, ack_pls_ff, nak_pls_ff;
  // axi slave state
  reg         aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  reg  [7:0]  awaddr_ff;
  reg  [31:0] wdata_ff, rdata_ff;
  reg  [3:0]  wstrb_ff;
  reg  [1:0]  bresp_ff, rresp_ff;
  // datapath
  reg  [15:0] freq_ff, freq_raw_ff;
  reg  [31:0] irms_a_ff, vrms_a_ff, irms_ff, vrms_ff, pact_ff, preact_ff;
  reg         dc_a_ff, stage_b_ff, valid_ff;
  // calibration divider
  reg  [1:0]  state_ff;
  reg  [30:0] num_ff, quo_ff;
  reg  [15:0] rem_ff;
  reg  [4:0]  cnt_ff;
  integer     i;

  wire [7:0] waddr    = {awaddr_ff[7:2], 2'b00};
  wire [7:0] raddr    = {S_AXI_ARADDR[7:2], 2'b00};
  wire       do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire       wr_ok    = do_write & mapped(waddr);
  wire       ar_take  = S_AXI_ARVALID & ~rvalid_ff;
  wire       ctrl_wr  = wr_ok & (waddr == `MCDP_OFS_CTRL) & wstrb_ff[0];
  wire       fcal_cmd = ctrl_wr & wdata_ff[`MCDP_CTRL_FCAL];
  wire       tcap_cmd = ctrl_wr & wdata_ff[`MCDP_CTRL_TCAP];
  wire       stat_wr  = wr_ok & (waddr == `MCDP_OFS_STAT) & wstrb_ff[0];
  wire [2:0] tc_widx  = waddr[4:2] - 3'd6;
  wire [2:0] tc_ridx  = raddr[4:2] - 3'd6;
  wire [15:0] tcal_wr = merge16({6'h0, tcal_ff}, wdata_ff, wstrb_ff);
  wire       in_band  = (freq_ff >= `MCDP_BAND_LO) & (freq_ff <= `MCDP_BAND_HI);

  // temperature selection, delta in raw ADC counts
  wire       t_hot  = TEMP_ADC > tcal_ff;
  wire       t_cold = TEMP_ADC < tcal_ff;
  wire [9:0] t_diff = t_hot ? TEMP_ADC - tcal_ff : tcal_ff - TEMP_ADC;

  // hot set above Tcal, cold set below, none at Tcal
  wire [15:0] c_freq = t_hot ? tcoef_ff[0] : (t_cold ? tcoef_ff[1] : 16'h0);
  wire [15:0] c_irms = t_hot ? tcoef_ff[2] : (t_cold ? tcoef_ff[3] : 16'h0);
  wire [15:0] c_pow  = t_hot ? tcoef_ff[4] : (t_cold ? tcoef_ff[5] : 16'h0);

  wire [31:0] fgain_prod = FREQ_RAW * fgain_ff;
  wire [15:0] freq_gain  = sat16(fgain_prod >> `MCDP_GAIN_SHIFT);
  wire [31:0] y_freq, y_irms, y_pact, y_preact, y_cap, y_drop;
  wire [47:0] fv_prod    = freq_ff * vrms_a_ff;

  // x*(1+c*dT) done as x +/- (c*|x|*|dT|)>>M
  mcdp_comp u_tc_freq (
    .x        ({16'h0, freq_gain}),
    .x_signed (1'b0),
    .coeff    (c_freq),
    .operand  ({32'h0, freq_gain} * t_diff),
    .shift    (`MCDP_TEMP_SHIFT),
    .subtract (t_cold),
    .y        (y_freq)
  );
  mcdp_comp u_tc_irms (
    .x        (IRMS_RAW),
    .x_signed (1'b0),
    .coeff    (c_irms),
    .operand  ({16'h0, IRMS_RAW} * t_diff),
    .shift    (`MCDP_TEMP_SHIFT),
    .subtract (t_cold),
    .y        (y_irms)
  );
  // signed power: term follows the sign of x, so flip for negatives
  mcdp_comp u_tc_pact (
    .x        (PACT_RAW),
    .x_signed (1'b1),
    .coeff    (c_pow),
    .operand  ({16'h0, mag32(PACT_RAW, 1'b1)} * t_diff),
    .shift    (`MCDP_TEMP_SHIFT),
    .subtract (t_cold ^ PACT_RAW[31]),
    .y        (y_pact)
  );
  mcdp_comp u_tc_preact (
    .x        (PREACT_RAW),
    .x_signed (1'b1),
    .coeff    (c_pow),
    .operand  ({16'h0, mag32(PREACT_RAW, 1'b1)} * t_diff),
    .shift    (`MCDP_TEMP_SHIFT),
    .subtract (t_cold ^ PREACT_RAW[31]),
    .y        (y_preact)
  );
  // capacitor current from compensated frequency and raw voltage
  mcdp_comp u_cap (
    .x        (irms_a_ff),
    .x_signed (1'b0),
    .coeff    (cap_coef_ff),
    .operand  (fv_prod),
    .shift    (shift_sel_ff[`MCDP_SHIFT_CAP_HI:`MCDP_SHIFT_CAP_LO]),
    .subtract (1'b0),
    .y        (y_cap)
  );
  // series drop uses the temperature-compensated current
  mcdp_comp u_drop (
    .x        (vrms_a_ff),
    .x_signed (1'b0),
    .coeff    (drop_coef_ff),
    .operand  ({16'h0, irms_a_ff}),
    .shift    (shift_sel_ff[`MCDP_SHIFT_DROP_HI:`MCDP_SHIFT_DROP_LO]),
    .subtract (1'b0),
    .y        (y_drop)
  );

  // two stages: frequency and temperature terms, then the cross terms
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      freq_ff     <= 16'h0;
      freq_raw_ff <= 16'h0;
      irms_a_ff   <= 32'h0;
      vrms_a_ff   <= 32'h0;
      irms_ff     <= 32'h0;
      vrms_ff     <= 32'h0;
      pact_ff     <= 32'h0;
      preact_ff   <= 32'h0;
      dc_a_ff     <= 1'b0;
      stage_b_ff  <= 1'b0;
      valid_ff    <= 1'b0;
    end else if (CE) begin
      stage_b_ff <= MEAS_STROBE;
      valid_ff   <= stage_b_ff;
      if (MEAS_STROBE) begin
        freq_raw_ff <= FREQ_RAW;
        freq_ff     <= DC_MODE ? 16'h0 : sat16(y_freq);
        irms_a_ff   <= y_irms;
        vrms_a_ff   <= VRMS_RAW;
        pact_ff     <= y_pact;
        preact_ff   <= y_preact;
        dc_a_ff     <= DC_MODE;
      end
      if (stage_b_ff) begin
        irms_ff <= dc_a_ff ? irms_a_ff : y_cap;
        vrms_ff <= y_drop;
      end
    end
  end

  // frequency calibration: gain = reference * 2^15 / raw frequency
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff   <= ST_IDLE;
      num_ff     <= 31'h0;
      quo_ff     <= 31'h0;
      rem_ff     <= 16'h0;
      cnt_ff     <= 5'h0;
      ack_pls_ff <= 1'b0;
      nak_pls_ff <= 1'b0;
    end else if (CE) begin
      ack_pls_ff <= 1'b0;
      nak_pls_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (fcal_cmd) begin
            if (DC_MODE || freq_raw_ff == 16'h0) begin
              nak_pls_ff <= 1'b1;
            end else begin
              num_ff   <= {fref_ff, 15'h0};
              quo_ff   <= 31'h0;
              rem_ff   <= 16'h0;
              cnt_ff   <= `MCDP_DIV_STEPS;
              state_ff <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if ({rem_ff, num_ff[30]} >= {1'b0, freq_raw_ff}) begin
            rem_ff <= {rem_ff[14:0], num_ff[30]} - freq_raw_ff;
            quo_ff <= {quo_ff[29:0], 1'b1};
          end else begin
            rem_ff <= {rem_ff[14:0], num_ff[30]};
            quo_ff <= {quo_ff[29:0], 1'b0};
          end
          num_ff <= {num_ff[29:0], 1'b0};
          cnt_ff <= cnt_ff - 5'd1;
          if (cnt_ff == 5'd1)
            state_ff <= ST_DONE;
        end
        ST_DONE: begin
          ack_pls_ff <= 1'b1;
          state_ff   <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // register file; calibration result overrides a same-cycle host write
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drop_coef_ff <= `MCDP_RST_DROP;
      cap_coef_ff  <= `MCDP_RST_CAP;
      shift_sel_ff <= `MCDP_RST_SHIFT;
      fref_ff      <= `MCDP_RST_FREF;
      fgain_ff     <= `MCDP_RST_FGAIN;
      tcal_ff      <= `MCDP_RST_TCAL;
      ack_ff       <= 1'b0;
      nak_ff       <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
        tcoef_ff[i] <= `MCDP_RST_TCOEF;
    end else if (CE) begin
      if (wr_ok) begin
        if (waddr == `MCDP_OFS_DROP)
          drop_coef_ff <= merge16(drop_coef_ff, wdata_ff, wstrb_ff);
        else if (waddr == `MCDP_OFS_CAP)
          cap_coef_ff <= merge16(cap_coef_ff, wdata_ff, wstrb_ff);
        else if (waddr == `MCDP_OFS_SHIFT)
          shift_sel_ff <= merge16(shift_sel_ff, wdata_ff, wstrb_ff);
        else if (waddr == `MCDP_OFS_FREF)
          fref_ff <= merge16(fref_ff, wdata_ff, wstrb_ff);
        else if (waddr == `MCDP_OFS_FGAIN)
          fgain_ff <= merge16(fgain_ff, wdata_ff, wstrb_ff);
        else if (waddr == `MCDP_OFS_TCAL)
          tcal_ff <= tcal_wr[9:0];
        else if (waddr >= `MCDP_OFS_TC_FIRST && waddr <= `MCDP_OFS_TC_LAST)
          tcoef_ff[tc_widx] <= merge16(tcoef_ff[tc_widx], wdata_ff, wstrb_ff);
      end
      if (tcap_cmd)
        tcal_ff <= TEMP_ADC;
      if (state_ff == ST_DONE)
        fgain_ff <= (quo_ff > 31'h0000_ffff) ? 16'hffff : quo_ff[15:0];
      // write-one-to-clear, a new event in the same cycle wins
      if (stat_wr && wdata_ff[`MCDP_STAT_ACK])
        ack_ff <= 1'b0;
      if (stat_wr && wdata_ff[`MCDP_STAT_NAK])
        nak_ff <= 1'b0;
      if (state_ff == ST_DONE)
        ack_ff <= 1'b1;
      if (ST_IDLE == state_ff && fcal_cmd &&
          (DC_MODE || freq_raw_ff == 16'h0))
        nak_ff <= 1'b1;
    end
  end

  // axi4-lite write: address and data held independently, then answered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `MCDP_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= S_AXI_WDATA;
        wstrb_ff  <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= mapped(waddr) ? `MCDP_RESP_OKAY : `MCDP_RESP_SLVERR;
      end else if (bvalid_ff && S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // axi4-lite read: one cycle from address handshake to data
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= `MCDP_RESP_OKAY;
    end else if (CE) begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= mapped(raddr) ? `MCDP_RESP_OKAY : `MCDP_RESP_SLVERR;
        rdata_ff  <= 32'h0;
        if (raddr == `MCDP_OFS_DROP)
          rdata_ff <= {16'h0, drop_coef_ff};
        else if (raddr == `MCDP_OFS_CAP)
          rdata_ff <= {16'h0, cap_coef_ff};
        else if (raddr == `MCDP_OFS_SHIFT)
          rdata_ff <= {16'h0, shift_sel_ff};
        else if (raddr == `MCDP_OFS_FREF)
          rdata_ff <= {16'h0, fref_ff};
        else if (raddr == `MCDP_OFS_FGAIN)
          rdata_ff <= {16'h0, fgain_ff};
        else if (raddr == `MCDP_OFS_TCAL)
          rdata_ff <= {22'h0, tcal_ff};
        else if (raddr >= `MCDP_OFS_TC_FIRST && raddr <= `MCDP_OFS_TC_LAST)
          rdata_ff <= {16'h0, tcoef_ff[tc_ridx]};
        else if (raddr == `MCDP_OFS_STAT)
          rdata_ff <= {27'h0, in_band, DC_MODE, state_ff != ST_IDLE,
                       nak_ff, ack_ff};
        else if (raddr == `MCDP_OFS_FREQ)
          rdata_ff <= {16'h0, freq_ff};
      end else if (rvalid_ff && S_AXI_RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = ~aw_held_ff;
  assign S_AXI_WREADY  = ~w_held_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign LINE_FREQ     = freq_ff;
  assign IRMS          = irms_ff;
  assign VRMS          = vrms_ff;
  assign PACT          = pact_ff;
  assign PREACT        = preact_ff;
  assign RESULT_VALID  = valid_ff;
  // band flag only qualifies the value, it does not clamp it
  assign FREQ_IN_BAND  = in_band;
  assign CAL_ACK       = ack_pls_ff;
  assign CAL_NAK       = nak_pls_ff;
endmodule // mcdp_top
`default_nettype wire

// ---- mcdp_top_sva.sv ----
// port-level assertions for the compensation datapath
`timescale 1ns/1ps
`default_nettype none
module mcdp_top_sva (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        DC_MODE,
  input wire logic        MEAS_STROBE,
  input wire logic [15:0] LINE_FREQ,
  input wire logic        RESULT_VALID,
  input wire logic        FREQ_IN_BAND,
  input wire logic        CAL_ACK,
  input wire logic        CAL_NAK,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence strobe_s;
    CE && MEAS_STROBE;
  endsequence
  sequence both_taken_s;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  chk_dc_zero:
    assert property (strobe_s ##0 DC_MODE |=> LINE_FREQ == 16'h0)
    else $error("line frequency not zero in dc mode");
  chk_band_flag:
    assert property (FREQ_IN_BAND ==
      (LINE_FREQ >= 16'hafc8 && LINE_FREQ <= 16'hfde8))
    else $error("in-band flag disagrees with line frequency");
  chk_valid_late:
    assert property (strobe_s |-> ##2 RESULT_VALID)
    else $error("result valid missing two cycles after strobe");
  chk_valid_cause:
    assert property (RESULT_VALID |-> $past(MEAS_STROBE, 2))
    else $error("result valid without earlier strobe");
  chk_ack_pulse:
    assert property (CAL_ACK |=> !CAL_ACK && !CAL_NAK)
    else $error("acknowledge longer than one cycle");
  chk_nak_pulse:
    assert property (CAL_NAK |-> !CAL_ACK ##1 !CAL_NAK)
    else $error("refusal pulse malformed");
  chk_write_resp:
    assert property (both_taken_s |=> !S_AXI_AWREADY ##1 S_AXI_BVALID)
    else $error("write response not two edges after take");
  chk_resp_drop:
    assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response held after acceptance");
  chk_read_resp:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data not one edge after take");
  chk_read_block:
    assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("read address accepted while data pending");
endmodule // mcdp_top_sva
bind mcdp_top mcdp_top_sva mcdp_top_sva_inst (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .DC_MODE(DC_MODE),
  .MEAS_STROBE(MEAS_STROBE), .LINE_FREQ(LINE_FREQ),
  .RESULT_VALID(RESULT_VALID), .FREQ_IN_BAND(FREQ_IN_BAND),
  .CAL_ACK(CAL_ACK), .CAL_NAK(CAL_NAK), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID)
);
`default_nettype wire

// ---- mcdp_host.sv ----
// host model: one register-bus write or read per request
`timescale 1ns/1ps
`default_nettype none
module mcdp_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] data,
  output var  logic        done,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  resp,
  output var  logic [7:0]  axi_addr,
  output var  logic [31:0] axi_wdata,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] axi_rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {awvalid, wvalid, bready, arvalid, rready, done} <= 6'h00;
      axi_addr <= 8'h00;
      axi_wdata <= 32'h0;
      rdata <= 32'h0;
      resp <= 2'h0;
    end else begin
      done <= 1'b0;
      if (go) begin
        axi_addr <= addr;
        axi_wdata <= data;
        {awvalid, wvalid, bready} <= {3{wr}};
        {arvalid, rready} <= {2{!wr}};
      end
      // each channel released only at its own handshake edge
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        resp <= bresp;
        done <= 1'b1;
      end
      if (rready && rvalid) begin
        rready <= 1'b0;
        rdata <= axi_rdata;
        resp <= rresp;
        done <= 1'b1;
      end
    end
  end
endmodule // mcdp_host
`default_nettype wire

// ---- measurement_compensation_datapath_test.sv ----
// self-checking bench for the compensation datapath
`timescale 1ns/1ps
`default_nettype none
`include "mcdp_map.vh"
module measurement_compensation_datapath_test;
  typedef struct {
    logic dc; logic [9:0] t; logic [15:0] f;
    logic [31:0] i, v, p, q;
    logic [15:0] elf; logic [31:0] ei, ev, ep, eq;
  } mcdp_row_t;
  logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, wr = 1'b0;
  logic        dc = 1'b0, stb = 1'b0, done, inband, ack, nak, rvo;
  logic        nak_seen = 1'b0;
  logic [7:0]  addr = 8'h00, axaddr;
  logic [9:0]  temp = 10'h200;
  logic [15:0] fraw = 16'h0, lf;
  logic [31:0] data = 32'h0, rdata, wdata, axrdata;
  logic [31:0] iraw = 32'h0, vraw = 32'h0, praw = 32'h0, qraw = 32'h0;
  logic [31:0] irms, vrms, pact, preact;
  logic [1:0]  resp, bresp, rresp;
  logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  int          fail_count = 0, total_checks = 0, cyc = 0, n;
  mcdp_row_t   cr;
  logic [1:0]  ok = `MCDP_RESP_OKAY, err = `MCDP_RESP_SLVERR;
  logic [31:0] tc [6] = '{32'h1000, 32'h2000, 32'h1000, 32'h0, 32'h0,
                          32'h1000};
  mcdp_row_t rows [5] = '{
    '{1'b0, 10'h200, 16'hc350, 32'h0, 32'h10000, 32'h64, 32'hffffff9c,
      16'hc350, 32'hc350, 32'h10000, 32'h64, 32'hffffff9c},
    '{1'b1, 10'h210, 16'hc350, 32'h10000, 32'h3e8, 32'h10000, 32'h0,
      16'h0, 32'h10100, 32'h104e8, 32'h10000, 32'h0},
    '{1'b0, 10'h1f0, 16'hc350, 32'h10000, 32'h0, 32'hffff0000, 32'h10000,
      16'hc1ca, 32'h10000, 32'h10000, 32'hffff0100, 32'hff00},
    '{1'b0, 10'h210, 16'h7530, 32'h0, 32'h100, 32'h5, 32'h5,
      16'h75a5, 32'h75, 32'h100, 32'h5, 32'h5},
    '{1'b1, 10'h210, 16'h0, 32'hffffff00, 32'h0, 32'h0, 32'h0,
      16'h0, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0}};

  mcdp_top mcdp_top_inst (
    .CLK(clk), .RST_N(rst_n), .CE(1'b1),
    .S_AXI_AWADDR(axaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(axaddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(axrdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .DC_MODE(dc), .MEAS_STROBE(stb),
    .TEMP_ADC(temp), .FREQ_RAW(fraw), .IRMS_RAW(iraw), .VRMS_RAW(vraw),
    .PACT_RAW(praw), .PREACT_RAW(qraw), .LINE_FREQ(lf), .IRMS(irms),
    .VRMS(vrms), .PACT(pact), .PREACT(preact), .RESULT_VALID(rvo),
    .FREQ_IN_BAND(inband), .CAL_ACK(ack), .CAL_NAK(nak));
  mcdp_host mcdp_host_inst (
    .clk(clk), .rst_n(rst_n), .go(go), .wr(wr), .addr(addr), .data(data),
    .done(done), .rdata(rdata), .resp(resp), .axi_addr(axaddr),
    .axi_wdata(wdata), .awvalid(awv), .awready(awr), .wvalid(wv),
    .wready(wrd), .bresp(bresp), .bvalid(bv), .bready(br), .arvalid(arv),
    .arready(arr), .axi_rdata(axrdata), .rresp(rresp), .rvalid(rv),
    .rready(rr));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // refusal pulse lasts one cycle, so latch it for the later check
    if (nak === 1'b1)
      nak_seen <= 1'b1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    data <= d;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    bus(1'b1, a, d);
    check("bresp", er, resp);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    bus(1'b0, a, 32'h0);
    check("rdata", ed, rdata);
    check("rresp", er, resp);
  endtask
  task automatic meas(input mcdp_row_t r);
    dc <= r.dc;
    temp <= r.t;
    fraw <= r.f;
    {iraw, vraw, praw, qraw} <= {r.i, r.v, r.p, r.q};
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    do @(posedge clk); while (rvo !== 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(`MCDP_OFS_DROP, 32'h0, ok);
    rreg(`MCDP_OFS_CAP, 32'h0, ok);
    rreg(`MCDP_OFS_SHIFT, {16'h0, 8'h1c, 8'h20}, ok);
    wreg(`MCDP_OFS_CAP, 32'hffffabcd, ok);
    rreg(`MCDP_OFS_CAP, 32'h0000abcd, ok);
    wreg(`MCDP_OFS_CAP, 32'h1, ok);
    wreg(`MCDP_OFS_DROP, 32'h100, ok);
    rreg(`MCDP_OFS_DROP, 32'h100, ok);
    wreg(`MCDP_OFS_SHIFT, 32'h0810, ok);
    for (int k = 0; k < 6; k++)
      wreg(`MCDP_OFS_TC_FIRST + 8'(4 * k), tc[k], ok);
    wreg(8'h3c, 32'h1, err);
    rreg(8'h3c, 32'h0, err);
    $display("test registers done");
    foreach (rows[k]) begin
      meas(rows[k]);
      check("line_freq", rows[k].elf, lf);
      check("irms", rows[k].ei, irms);
      check("vrms", rows[k].ev, vrms);
      check("pact", rows[k].ep, pact);
      check("preact", rows[k].eq, preact);
      check("in_band", rows[k].elf >= 16'hafc8 && rows[k].elf <= 16'hfde8,
            inband);
      $display("test row %0d done", k);
    end
    cr = rows[0];
    cr.f = 16'h9c40;
    meas(cr);
    wreg(`MCDP_OFS_CTRL, 32'h1, ok);
    for (n = 0; n < 40 && ack !== 1'b1; n++) @(posedge clk);
    check("cal_ack", 1'b1, ack);
    rreg(`MCDP_OFS_FGAIN, 32'ha000, ok);
    meas(cr);
    check("line_freq", 16'hc350, lf);
    rreg(`MCDP_OFS_STAT, 32'h11, ok);
    $display("test calibration done");
    cr.dc = 1'b1;
    meas(cr);
    wreg(`MCDP_OFS_CTRL, 32'h1, ok);
    for (n = 0; n < 5 && nak_seen !== 1'b1; n++) @(posedge clk);
    check("cal_nak", 1'b1, nak_seen);
    rreg(`MCDP_OFS_FGAIN, 32'ha000, ok);
    rreg(`MCDP_OFS_STAT, 32'h0b, ok);
    $display("test dc refusal done");
    temp <= 10'h155;
    wreg(`MCDP_OFS_CTRL, 32'h2, ok);
    rreg(`MCDP_OFS_TCAL, 32'h155, ok);
    $display("test reference capture done");
    test_done();
  end
endmodule // measurement_compensation_datapath_test
`default_nettype wire
